// File: src/lslc_pkg.sv
// constants for the led sink latch control block
package lslc_pkg;
  localparam int SHIFT_W = 25;
  localparam int LATCH_W = 24;
  localparam int SINKS_PER_GROUP = 8;
  localparam int BRIGHT_W = 7;
  localparam int SEL_BIT = 24;
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 7;
  localparam int BLUE_LSB = 14;
  localparam int DETECT_LSB = 21;
  localparam int DETECT_W = 3;
  localparam logic SEL_ENABLE = 1'h0;
  localparam logic SEL_SETUP = 1'h1;
  localparam logic [23:0] ENABLE_RESET = 24'h000000;
  localparam logic [23:0] SETUP_RESET = 24'h000000;
  localparam int SYNC_STAGES = 3;
  localparam real CLK_PERIOD_NS = 40.0;
endpackage

// File: src/lslc_sync_edge.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
module lslc_sync_edge (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pin side
  input wire logic pin_in,
  // filtered level and rising-edge pulse
  output logic level_out,
  output logic rise_out
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;

  // stage 0 feeds only stage 1; the filter looks at stages 1 and 2
  always_comb begin
    stage_d = {stage_q[1:0], pin_in};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
    rise_d = level_d & ~level_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage_q <= 3'h0;
      level_q <= 1'h0;
      rise_q <= 1'h0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign level_out = level_q;
  assign rise_out = rise_q;
endmodule

// File: src/lslc_top.sv
// led sink latch control: serial shift register, two latches, sink gating
`timescale 1ns/10ps
module lslc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial host pins
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic blank,
  output logic serial_out,
  // sink gates
  output logic [7:0] red_sink,
  output logic [7:0] green_sink,
  output logic [7:0] blue_sink,
  // analog current and detection settings
  output logic [6:0] red_brightness,
  output logic [6:0] green_brightness,
  output logic [6:0] blue_brightness,
  output logic [2:0] detect_select,
  output logic open_led_detect,
  output logic short_led_detect
);
  logic sclk_rise;
  logic strobe_rise;
  logic din_lvl;
  logic blank_lvl;
  logic [lslc_pkg::SHIFT_W-1:0] shift_q;
  logic [lslc_pkg::SHIFT_W-1:0] shift_d;
  logic [lslc_pkg::LATCH_W-1:0] sink_enable_latch_q;
  logic [lslc_pkg::LATCH_W-1:0] sink_enable_latch_d;
  logic [lslc_pkg::LATCH_W-1:0] group_setup_latch_q;
  logic [lslc_pkg::LATCH_W-1:0] group_setup_latch_d;
  logic [lslc_pkg::LATCH_W-1:0] gated_q;
  logic [lslc_pkg::LATCH_W-1:0] gated_d;
  logic [lslc_pkg::LATCH_W-1:0] shift_low;

  lslc_sync_edge u_sclk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(serial_clk),
    .level_out(),
    .rise_out(sclk_rise)
  );

  lslc_sync_edge u_strobe (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(latch_strobe),
    .level_out(),
    .rise_out(strobe_rise)
  );

  // data passes the same filter so it lines up with the clock edge pulse
  lslc_sync_edge u_din (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(serial_in),
    .level_out(din_lvl),
    .rise_out()
  );

  lslc_sync_edge u_blank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(blank),
    .level_out(blank_lvl),
    .rise_out()
  );

  function automatic logic [6:0] field7(input logic [23:0] w, input int lsb);
    field7 = w[lsb +: lslc_pkg::BRIGHT_W];
  endfunction

  function automatic logic [7:0] sink_group(input logic [23:0] w, input int grp);
    sink_group = w[grp * lslc_pkg::SINKS_PER_GROUP +: lslc_pkg::SINKS_PER_GROUP];
  endfunction

  // top code bit splits open detection from short detection
  function automatic logic is_short_code(input logic [2:0] code);
    is_short_code = code[lslc_pkg::DETECT_W-1];
  endfunction

  // shift register group
  always_comb begin
    shift_d = shift_q;
    if (sclk_rise) begin
      shift_d = {shift_q[lslc_pkg::SHIFT_W-2:0], din_lvl};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  assign shift_low = shift_q[lslc_pkg::LATCH_W-1:0];

  // latch group: the selector bit steers one transfer per strobe edge
  always_comb begin
    sink_enable_latch_d = sink_enable_latch_q;
    group_setup_latch_d = group_setup_latch_q;
    if (strobe_rise) begin
      if (shift_q[lslc_pkg::SEL_BIT] == lslc_pkg::SEL_ENABLE) begin
        sink_enable_latch_d = shift_low;
      end else begin
        group_setup_latch_d = shift_low;
      end
    end
  end

  // power-up contents have no defined value; zero keeps sinks dark until loaded
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sink_enable_latch_q <= lslc_pkg::ENABLE_RESET;
      group_setup_latch_q <= lslc_pkg::SETUP_RESET;
    end else begin
      sink_enable_latch_q <= sink_enable_latch_d;
      group_setup_latch_q <= group_setup_latch_d;
    end
  end

  // blank wins over the latch contents
  always_comb begin
    gated_d = blank_lvl ? '0 : sink_enable_latch_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gated_q <= '0;
    end else begin
      gated_q <= gated_d;
    end
  end

  assign serial_out = shift_q[lslc_pkg::SHIFT_W-1];
  assign red_sink = sink_group(gated_q, 0);
  assign green_sink = sink_group(gated_q, 1);
  assign blue_sink = sink_group(gated_q, 2);
  // brightness feeds the current dacs straight from the latch, no extra event
  assign red_brightness = field7(group_setup_latch_q, lslc_pkg::RED_LSB);
  assign green_brightness = field7(group_setup_latch_q, lslc_pkg::GREEN_LSB);
  assign blue_brightness = field7(group_setup_latch_q, lslc_pkg::BLUE_LSB);
  assign detect_select = group_setup_latch_q[lslc_pkg::DETECT_LSB +: lslc_pkg::DETECT_W];
  assign open_led_detect = ~is_short_code(detect_select);
  assign short_led_detect = is_short_code(detect_select);

  // sink gating
  AST_BLANK_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    blank_lvl |=> gated_q == '0) else $error("sinks on while blanked");
  AST_SINK_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !blank_lvl |=> gated_q == $past(sink_enable_latch_q)) else $error("sink mismatch");
  AST_SINK_MAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    {blue_sink, green_sink, red_sink} == gated_q) else $error("sink group order");

  sequence s_strobe_enable;
    strobe_rise && !shift_q[lslc_pkg::SEL_BIT];
  endsequence
  sequence s_strobe_setup;
    strobe_rise && shift_q[lslc_pkg::SEL_BIT];
  endsequence
  // an enable transfer followed by an unblanked cycle reaches the sinks
  sequence s_enable_then_lit;
    s_strobe_enable ##1 !blank_lvl;
  endsequence

  // latch transfers
  AST_LOAD_ENABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strobe_enable |=> sink_enable_latch_q == $past(shift_low)) else $error("enable load");
  AST_LOAD_SETUP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strobe_setup |=> group_setup_latch_q == $past(shift_low)) else $error("setup load");
  AST_SETUP_UNTOUCHED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strobe_enable |=> $stable(group_setup_latch_q)) else $error("setup hit by enable write");
  AST_ENABLE_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strobe_setup |=> $stable(sink_enable_latch_q)) else $error("enable hit by setup write");
  AST_SETUP_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !strobe_rise |=> $stable(group_setup_latch_q)) else $error("setup changed without strobe");
  AST_ENABLE_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !strobe_rise |=> $stable(sink_enable_latch_q)) else $error("enable changed without strobe");
  AST_STROBE_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    strobe_rise |=> !strobe_rise) else $error("strobe edge longer than one cycle");
  AST_STROBE_TO_SINK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_enable_then_lit |=> gated_q == $past(shift_low, 2)) else $error("strobe to sink path");
  AST_SETUP_APPLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strobe_setup |=> {detect_select, blue_brightness, green_brightness, red_brightness}
    == $past(shift_low)) else $error("setup not applied at once");

  // serial shifting
  AST_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sclk_rise |=> shift_q == {$past(shift_low), $past(din_lvl)}) else $error("shift");
  AST_SHIFT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !sclk_rise |=> $stable(shift_q)) else $error("shift without serial clock edge");
  AST_SCLK_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sclk_rise |=> !sclk_rise) else $error("serial clock edge longer than one cycle");

  // setup field decode
  AST_BRIGHT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    blue_brightness == group_setup_latch_q[20:14] && red_brightness == group_setup_latch_q[6:0])
    else $error("brightness field");
  AST_GREEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    green_brightness == group_setup_latch_q[13:7]) else $error("green brightness field");
  AST_DETECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    open_led_detect == (group_setup_latch_q[23:21] < 3'h4)) else $error("detect type");
  AST_SHORT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    short_led_detect == (group_setup_latch_q[23:21] > 3'h3)) else $error("short detect type");
  AST_ONE_DETECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    open_led_detect != short_led_detect) else $error("both detection types selected");
endmodule

// File: tb/lslc_host_model.sv
// host model driving the serial, strobe and blank pins
`timescale 1ns/10ps
module lslc_host_model (
  // clock
  input wire logic ref_clk,
  // serial host pins
  output logic serial_clk,
  output logic serial_in,
  output logic latch_strobe,
  output logic blank
);
  initial begin
    serial_clk = 1'h0;
    serial_in = 1'h0;
    latch_strobe = 1'h0;
    blank = 1'h1;
  end
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic set_blank(input logic b);
    blank = b;
  endtask
  task automatic send(input logic [24:0] word);
    for (int i = 24; i >= 0; i--) begin
      serial_in = word[i];
      half();
      serial_clk = 1'h1;
      half();
      serial_clk = 1'h0;
    end
    // data no longer held: show a changed level
    serial_in = ~word[0];
    half();
    latch_strobe = 1'h1;
    half();
    latch_strobe = 1'h0;
  endtask
endmodule

// File: tb/lslc_top_tb_top.sv
// self-checking bench for the led sink latch control block
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module lslc_top_tb_top;
  logic ref_clk, rst_n, serial_clk, serial_in, latch_strobe, blank, serial_out;
  logic [7:0] red_sink, green_sink, blue_sink;
  logic [6:0] red_brightness, green_brightness, blue_brightness;
  logic [2:0] detect_select;
  logic open_led_detect, short_led_detect;
  logic [23:0] exp_en = 24'h000000;
  logic [23:0] exp_su = 24'h000000;
  logic [31:0] r;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 64024;
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  lslc_top i_lslc_top (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe), .blank(blank),
    .serial_out(serial_out), .red_sink(red_sink), .green_sink(green_sink),
    .blue_sink(blue_sink), .red_brightness(red_brightness),
    .green_brightness(green_brightness), .blue_brightness(blue_brightness),
    .detect_select(detect_select), .open_led_detect(open_led_detect),
    .short_led_detect(short_led_detect));
  lslc_host_model i_lslc_host_model (.ref_clk(ref_clk), .serial_clk(serial_clk),
    .serial_in(serial_in), .latch_strobe(latch_strobe), .blank(blank));
  function automatic logic [23:0] sinks_of(logic [23:0] en, logic blk);
    return blk ? 24'h000000 : en;
  endfunction
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check_all();
    `CHECK("sinks", sinks_of(exp_en, blank), {blue_sink, green_sink, red_sink})
    `CHECK("red", exp_su[6:0], red_brightness)
    `CHECK("green", exp_su[13:7], green_brightness)
    `CHECK("blue", exp_su[20:14], blue_brightness)
    `CHECK("detect", exp_su[23:21], detect_select)
    `CHECK("open", ~exp_su[23], open_led_detect)
    `CHECK("short", exp_su[23], short_led_detect)
  endtask
  task automatic write(input logic sel, input logic [23:0] data);
    i_lslc_host_model.send({sel, data});
    `CHECK("serial_out", sel, serial_out)
    if (sel) exp_su = data;
    else exp_en = data;
    repeat (12) @(negedge ref_clk);
    check_all();
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'h1;
    repeat (2) @(negedge ref_clk);
    check_all();
    write(1'h1, 24'hFFFFFF);
    write(1'h0, 24'h000000);
    i_lslc_host_model.set_blank(1'h0);
    write(1'h0, 24'hA5C33C);
    for (int c = 0; c < 8; c++) write(1'h1, {c[2:0], 21'h0AB5A5});
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      write(r[24], r[23:0]);
      // blank toggles while the enable latch holds
      i_lslc_host_model.set_blank(k[0]);
      repeat (12) @(negedge ref_clk);
      check_all();
    end
    // reset mid-run: both latches return to their zero state
    rst_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'h1;
    exp_en = 24'h000000;
    exp_su = 24'h000000;
    repeat (2) @(negedge ref_clk);
    check_all();
    write(1'h0, 24'h3C5AA5);
    i_lslc_host_model.set_blank(1'h0);
    repeat (12) @(negedge ref_clk);
    check_all();
    stop_test();
  end
endmodule
